// ---- rtl/sbd_decoder.sv ----
`timescale 1ns/10ps
`default_nettype none
module sbd_decoder
	import sbd_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       srst,
	input  wire logic       tap_reset_state,
	input  wire logic       update_ir,
	input  wire logic [7:0] ir_value,
	input  wire logic       bridge_selected,
	output sbd_dr_t         dr_sel,
	output logic            ext_test_mode,
	output logic            join_local_ports,
	output logic            hold_ports_in_reset_state,
	output logic            hold_ports_in_idle_state,
	output logic            hold_ports_in_pause_state,
	output logic            return_to_address_wait,
	output logic            soft_reset_cmd,
	output logic            signature_enable_cmd,
	output logic            signature_disable_cmd,
	output logic            clock_count_start_cmd,
	output logic            clock_count_stop_cmd
);
	//--------------------------------------------------------------
	// opcode lookup
	//--------------------------------------------------------------
	sbd_dr_t  tbl_dr;
	sbd_act_t tbl_act;
	logic     tbl_ext;

	sbd_opcode_table u_table (
		.opcode      (ir_value),
		.dr_sel      (tbl_dr),
		.action      (tbl_act),
		.is_ext_test (tbl_ext)
	);

	// a decode only counts while the bridge is selected, except return-to-wait
	logic take;
	logic take_wait;
	assign take      = update_ir && bridge_selected;
	assign take_wait = update_ir && (ir_value == OP_RETURN_WAIT);

	//--------------------------------------------------------------
	// data register selection
	//--------------------------------------------------------------
	sbd_dr_t dr_sel_next;
	sbd_dr_t dr_sel_reg;

	// the tap reset state wins over an update in the same cycle
	always_comb begin
		dr_sel_next = dr_sel_reg;
		if (tap_reset_state) begin
			dr_sel_next = SBD_DR_IDENT;
		end else if (take) begin
			dr_sel_next = tbl_dr;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			dr_sel_reg <= SBD_DR_IDENT;
		end else begin
			dr_sel_reg <= dr_sel_next;
		end
	end

	assign dr_sel = dr_sel_reg;

	//--------------------------------------------------------------
	// external test flag
	//--------------------------------------------------------------
	logic ext_test_next;
	logic ext_test_reg;

	always_comb begin
		ext_test_next = ext_test_reg;
		if (tap_reset_state) begin
			ext_test_next = 1'b0;
		end else if (take) begin
			ext_test_next = tbl_ext;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			ext_test_reg <= 1'b0;
		end else begin
			ext_test_reg <= ext_test_next;
		end
	end

	assign ext_test_mode = ext_test_reg;

	//--------------------------------------------------------------
	// join local ports pulse
	//--------------------------------------------------------------
	// every command pulse stands for exactly one cycle after its update
	logic join_next;
	logic join_reg;

	assign join_next = take && (tbl_act == SBD_ACT_JOIN);

	always_ff @(posedge clock) begin
		if (srst) begin
			join_reg <= 1'b0;
		end else begin
			join_reg <= join_next;
		end
	end

	assign join_local_ports = join_reg;

	//--------------------------------------------------------------
	// hold ports in reset state pulse
	//--------------------------------------------------------------
	logic park_reset_next;
	logic park_reset_reg;

	assign park_reset_next = take && (tbl_act == SBD_ACT_PARK_RESET);

	always_ff @(posedge clock) begin
		if (srst) begin
			park_reset_reg <= 1'b0;
		end else begin
			park_reset_reg <= park_reset_next;
		end
	end

	assign hold_ports_in_reset_state = park_reset_reg;

	//--------------------------------------------------------------
	// hold ports in idle state pulse
	//--------------------------------------------------------------
	logic park_idle_next;
	logic park_idle_reg;

	assign park_idle_next = take && (tbl_act == SBD_ACT_PARK_IDLE);

	always_ff @(posedge clock) begin
		if (srst) begin
			park_idle_reg <= 1'b0;
		end else begin
			park_idle_reg <= park_idle_next;
		end
	end

	assign hold_ports_in_idle_state = park_idle_reg;

	//--------------------------------------------------------------
	// hold ports in pause state pulse
	//--------------------------------------------------------------
	logic park_pause_next;
	logic park_pause_reg;

	assign park_pause_next = take && (tbl_act == SBD_ACT_PARK_PAUSE);

	always_ff @(posedge clock) begin
		if (srst) begin
			park_pause_reg <= 1'b0;
		end else begin
			park_pause_reg <= park_pause_next;
		end
	end

	assign hold_ports_in_pause_state = park_pause_reg;

	//--------------------------------------------------------------
	// return to address wait pulse
	//--------------------------------------------------------------
	// fires whether or not the bridge is selected
	logic wait_next;
	logic wait_reg;

	assign wait_next = take_wait;

	always_ff @(posedge clock) begin
		if (srst) begin
			wait_reg <= 1'b0;
		end else begin
			wait_reg <= wait_next;
		end
	end

	assign return_to_address_wait = wait_reg;

	//--------------------------------------------------------------
	// soft reset pulse
	//--------------------------------------------------------------
	logic soft_reset_next;
	logic soft_reset_reg;

	assign soft_reset_next = take && (tbl_act == SBD_ACT_SOFT_RESET);

	always_ff @(posedge clock) begin
		if (srst) begin
			soft_reset_reg <= 1'b0;
		end else begin
			soft_reset_reg <= soft_reset_next;
		end
	end

	assign soft_reset_cmd = soft_reset_reg;

	//--------------------------------------------------------------
	// signature compactor enable pulse
	//--------------------------------------------------------------
	logic sig_on_next;
	logic sig_on_reg;

	assign sig_on_next = take && (tbl_act == SBD_ACT_SIG_ON);

	always_ff @(posedge clock) begin
		if (srst) begin
			sig_on_reg <= 1'b0;
		end else begin
			sig_on_reg <= sig_on_next;
		end
	end

	assign signature_enable_cmd = sig_on_reg;

	//--------------------------------------------------------------
	// signature compactor disable pulse
	//--------------------------------------------------------------
	logic sig_off_next;
	logic sig_off_reg;

	assign sig_off_next = take && (tbl_act == SBD_ACT_SIG_OFF);

	always_ff @(posedge clock) begin
		if (srst) begin
			sig_off_reg <= 1'b0;
		end else begin
			sig_off_reg <= sig_off_next;
		end
	end

	assign signature_disable_cmd = sig_off_reg;

	//--------------------------------------------------------------
	// clock counter start pulse
	//--------------------------------------------------------------
	logic cnt_start_next;
	logic cnt_start_reg;

	assign cnt_start_next = take && (tbl_act == SBD_ACT_CNT_START);

	always_ff @(posedge clock) begin
		if (srst) begin
			cnt_start_reg <= 1'b0;
		end else begin
			cnt_start_reg <= cnt_start_next;
		end
	end

	assign clock_count_start_cmd = cnt_start_reg;

	//--------------------------------------------------------------
	// clock counter stop pulse
	//--------------------------------------------------------------
	logic cnt_stop_next;
	logic cnt_stop_reg;

	assign cnt_stop_next = take && (tbl_act == SBD_ACT_CNT_STOP);

	always_ff @(posedge clock) begin
		if (srst) begin
			cnt_stop_reg <= 1'b0;
		end else begin
			cnt_stop_reg <= cnt_stop_next;
		end
	end

	assign clock_count_stop_cmd = cnt_stop_reg;
endmodule : sbd_decoder
`default_nettype wire

// ---- rtl/sbd_pkg.sv ----
`default_nettype none
package sbd_pkg;
	// instruction opcodes
	localparam logic [7:0] OP_BYPASS        = 8'hFF;
	localparam logic [7:0] OP_EXTEST        = 8'h00;
	localparam logic [7:0] OP_SAMPLE        = 8'h81;
	localparam logic [7:0] OP_IDCODE        = 8'hAA;
	localparam logic [7:0] OP_JOIN          = 8'hE7;
	localparam logic [7:0] OP_PARK_RESET    = 8'hC5;
	localparam logic [7:0] OP_PARK_IDLE     = 8'h84;
	localparam logic [7:0] OP_PARK_PAUSE    = 8'hC6;
	localparam logic [7:0] OP_RETURN_WAIT   = 8'hC3;
	localparam logic [7:0] OP_MODE0         = 8'h8E;
	localparam logic [7:0] OP_MODE1         = 8'h82;
	localparam logic [7:0] OP_MODE2         = 8'h83;
	localparam logic [7:0] OP_MODE3         = 8'h85;
	localparam logic [7:0] OP_GROUP         = 8'h03;
	localparam logic [7:0] OP_SOFT_RESET    = 8'h88;
	localparam logic [7:0] OP_SIG_SEL       = 8'hC9;
	localparam logic [7:0] OP_SIG_ON        = 8'h0C;
	localparam logic [7:0] OP_SIG_OFF       = 8'h8D;
	localparam logic [7:0] OP_CNT_SEL       = 8'hCE;
	localparam logic [7:0] OP_CNT_START     = 8'h0F;
	localparam logic [7:0] OP_CNT_STOP      = 8'h90;
	// instruction register value after reset
	localparam logic [7:0] IR_RESET_VALUE   = OP_IDCODE;

	typedef enum logic [3:0] {
		SBD_DR_BYPASS,
		SBD_DR_BOUNDARY,
		SBD_DR_IDENT,
		SBD_DR_MODE0,
		SBD_DR_MODE1,
		SBD_DR_MODE2,
		SBD_DR_MODE3,
		SBD_DR_GROUP,
		SBD_DR_SIGNATURE,
		SBD_DR_CLOCK_COUNT
	} sbd_dr_t;

	typedef enum logic [3:0] {
		SBD_ACT_NONE,
		SBD_ACT_JOIN,
		SBD_ACT_PARK_RESET,
		SBD_ACT_PARK_IDLE,
		SBD_ACT_PARK_PAUSE,
		SBD_ACT_RETURN_WAIT,
		SBD_ACT_SOFT_RESET,
		SBD_ACT_SIG_ON,
		SBD_ACT_SIG_OFF,
		SBD_ACT_CNT_START,
		SBD_ACT_CNT_STOP
	} sbd_act_t;
endpackage : sbd_pkg
`default_nettype wire

// ---- rtl/sbd_opcode_table.sv ----
`timescale 1ns/10ps
`default_nettype none
// pure lookup: opcode to data register and control action
module sbd_opcode_table
	import sbd_pkg::*;
(
	input  wire logic [7:0] opcode,
	output sbd_dr_t         dr_sel,
	output sbd_act_t        action,
	output logic            is_ext_test
);
	always_comb begin
		dr_sel      = SBD_DR_IDENT;
		action      = SBD_ACT_NONE;
		is_ext_test = 1'b0;
		// full eight-bit compare on every entry
		case (opcode)
			OP_BYPASS:      dr_sel = SBD_DR_BYPASS;
			OP_EXTEST: begin
				dr_sel      = SBD_DR_BOUNDARY;
				is_ext_test = 1'b1;
			end
			OP_SAMPLE:      dr_sel = SBD_DR_BOUNDARY;
			OP_IDCODE:      dr_sel = SBD_DR_IDENT;
			OP_JOIN:        action = SBD_ACT_JOIN;
			OP_PARK_RESET:  action = SBD_ACT_PARK_RESET;
			OP_PARK_IDLE:   action = SBD_ACT_PARK_IDLE;
			OP_PARK_PAUSE:  action = SBD_ACT_PARK_PAUSE;
			OP_RETURN_WAIT: action = SBD_ACT_RETURN_WAIT;
			OP_MODE0:       dr_sel = SBD_DR_MODE0;
			OP_MODE1:       dr_sel = SBD_DR_MODE1;
			OP_MODE2:       dr_sel = SBD_DR_MODE2;
			OP_MODE3:       dr_sel = SBD_DR_MODE3;
			OP_GROUP:       dr_sel = SBD_DR_GROUP;
			OP_SOFT_RESET:  action = SBD_ACT_SOFT_RESET;
			OP_SIG_SEL:     dr_sel = SBD_DR_SIGNATURE;
			OP_SIG_ON:      action = SBD_ACT_SIG_ON;
			OP_SIG_OFF:     action = SBD_ACT_SIG_OFF;
			OP_CNT_SEL:     dr_sel = SBD_DR_CLOCK_COUNT;
			OP_CNT_START:   action = SBD_ACT_CNT_START;
			OP_CNT_STOP:    action = SBD_ACT_CNT_STOP;
			default:        dr_sel = SBD_DR_IDENT;
		endcase
	end
endmodule : sbd_opcode_table
`default_nettype wire

// ---- verification/sbd_decoder_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
module sbd_chk
	import sbd_pkg::*;
(
	input wire logic       clock,
	input wire logic       srst,
	input wire logic       tap_reset_state,
	input wire logic       update_ir,
	input wire logic [7:0] ir_value,
	input wire logic       bridge_selected,
	input wire sbd_dr_t    dr_sel,
	input wire logic       ext_test_mode,
	input wire logic       join_local_ports,
	input wire logic       return_to_address_wait,
	input wire logic       soft_reset_cmd
);
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	sequence upd(logic [7:0] op);
		update_ir && bridge_selected && !tap_reset_state && ir_value == op;
	endsequence
	sequence one_join;
		join_local_ports ##1 !join_local_ports;
	endsequence
	byp_sel_a: assert property (upd(8'hFF) |=> dr_sel == SBD_DR_BYPASS)
		else $error("bypass not chosen");
	ext_sel_a: assert property (upd(8'h00) |=> dr_sel == SBD_DR_BOUNDARY && ext_test_mode)
		else $error("ext test wrong");
	smp_sel_a: assert property (upd(8'h81) |=> dr_sel == SBD_DR_BOUNDARY && !ext_test_mode)
		else $error("sample wrong");
	mode_zero_a: assert property (upd(8'h8E) |=> dr_sel == SBD_DR_MODE0)
		else $error("mode zero not chosen");
	join_once_a: assert property (upd(8'hE7) ##1 !update_ir |-> one_join)
		else $error("join pulse wrong");
	wait_pulse_a: assert property (update_ir && ir_value == 8'hC3 |=> return_to_address_wait)
		else $error("return pulse missing");
	sel_hold_a: assert property (!update_ir && !tap_reset_state |=> $stable(dr_sel))
		else $error("selection moved");
	idle_quiet_a: assert property (!update_ir |=> !(join_local_ports || return_to_address_wait || soft_reset_cmd))
		else $error("stray pulse");
endmodule : sbd_chk
bind sbd_decoder sbd_chk u_chk (.clock, .srst, .tap_reset_state, .update_ir, .ir_value,
	.bridge_selected, .dr_sel, .ext_test_mode, .join_local_ports, .return_to_address_wait,
	.soft_reset_cmd);
`default_nettype wire

// ---- verification/sbd_master_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module sbd_master_model (
	input  wire logic  clock,
	output logic       update_ir,
	output logic [7:0] ir_value,
	output logic       bridge_selected
);
	initial begin
		update_ir = 1'b0;
		ir_value = 8'h55;
		bridge_selected = 1'b0;
	end
	task automatic issue(input logic [7:0] op, input logic sel);
		@(posedge clock);
		#1;
		update_ir = 1'b1;
		ir_value = op;
		bridge_selected = sel;
		@(posedge clock);
		#1;
		update_ir = 1'b0;
		// stale code flips so it is never reused by accident
		ir_value = ~op;
	endtask : issue
endmodule : sbd_master_model
`default_nettype wire

// ---- verification/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_top
	import sbd_pkg::*;
;
	logic clock;
	logic srst;
	logic tap_reset_state;
	wire logic update_ir;
	wire logic bridge_selected;
	wire logic [7:0] ir_value;
	wire logic [14:0] outs;
	int n_errors = 0;
	int comparisons = 0;
	localparam logic [7:0] DR_OPS [10] = '{8'hFF, 8'h00, 8'h81, 8'h8E, 8'h82, 8'h83, 8'h85,
		8'h03, 8'hC9, 8'hCE};
	localparam sbd_dr_t DR_VAL [10] = '{SBD_DR_BYPASS, SBD_DR_BOUNDARY, SBD_DR_BOUNDARY,
		SBD_DR_MODE0, SBD_DR_MODE1, SBD_DR_MODE2, SBD_DR_MODE3, SBD_DR_GROUP,
		SBD_DR_SIGNATURE, SBD_DR_CLOCK_COUNT};
	localparam logic [7:0] ACT_OPS [10] = '{8'hE7, 8'hC5, 8'h84, 8'hC6, 8'hC3, 8'h88, 8'h0C,
		8'h8D, 8'h0F, 8'h90};
	sbd_master_model u_mst (.clock, .update_ir, .ir_value, .bridge_selected);
	sbd_decoder u_dut (.clock, .srst, .tap_reset_state, .update_ir, .ir_value,
		.bridge_selected, .dr_sel(outs[13:10]), .ext_test_mode(outs[14]),
		.join_local_ports(outs[9]), .hold_ports_in_reset_state(outs[8]),
		.hold_ports_in_idle_state(outs[7]), .hold_ports_in_pause_state(outs[6]),
		.return_to_address_wait(outs[5]), .soft_reset_cmd(outs[4]),
		.signature_enable_cmd(outs[3]), .signature_disable_cmd(outs[2]),
		.clock_count_start_cmd(outs[1]), .clock_count_stop_cmd(outs[0]));
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	// ext flag, selection, then one bit per action
	function automatic logic [14:0] expect_out(input logic [7:0] op);
		sbd_dr_t d;
		logic [9:0] a;
		d = SBD_DR_IDENT;
		a = 10'h000;
		for (int k = 0; k < 10; k++) begin
			if (op == DR_OPS[k]) d = DR_VAL[k];
			if (op == ACT_OPS[k]) a[9 - k] = 1'b1;
		end
		return {op == 8'h00, d, a};
	endfunction : expect_out
	task automatic chk(input logic [14:0] got, input logic [14:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic end_of_test();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_of_test
	task automatic t_all_codes();
		for (int i = 0; i < 256; i++) begin
			u_mst.issue(8'(i), 1'b1);
			chk(outs, expect_out(8'(i)));
		end
	endtask : t_all_codes
	task automatic t_unselected();
		u_mst.issue(8'h8E, 1'b1);
		u_mst.issue(8'hFF, 1'b0);
		chk(outs, {1'b0, SBD_DR_MODE0, 10'h000});
		u_mst.issue(8'hC3, 1'b0);
		chk(outs, {1'b0, SBD_DR_MODE0, 10'h020});
	endtask : t_unselected
	task automatic t_resets();
		u_mst.issue(8'hC9, 1'b1);
		tap_reset_state = 1'b1;
		@(posedge clock);
		#1;
		tap_reset_state = 1'b0;
		chk(outs, {1'b0, SBD_DR_IDENT, 10'h000});
		u_mst.issue(8'h00, 1'b1);
		srst = 1'b1;
		@(posedge clock);
		#1;
		srst = 1'b0;
		chk(outs, {1'b0, SBD_DR_IDENT, 10'h000});
		u_mst.issue(8'h0C, 1'b1);
		chk(outs, expect_out(8'h0C));
	endtask : t_resets
	initial begin
		srst = 1'b1;
		tap_reset_state = 1'b0;
		repeat (10) @(posedge clock);
		#1;
		srst = 1'b0;
		t_all_codes();
		t_unselected();
		t_resets();
		end_of_test();
	end
	initial begin
		#200000;
		n_errors++;
		end_of_test();
	end
endmodule : tb_top
`default_nettype wire
